// [include/fasp_pkg.sv]
// Constants, codes and timing counts for the flash identification and
// sector-protection host controller.
// Assumes a 100 MHz system clock and a flash wired in word mode.
package fasp_pkg;

	// --------------------
	// Clock and timing
	// --------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int T_ACC_NS      = 120;  // Read strobe to valid data
	localparam int T_WP_NS       = 50;   // Write strobe width
	localparam int T_VID_SET_NS  = 4000; // Elevated level settle time
	localparam int SYNC_STAGES   = 2;
	localparam int ACC_CYC       = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES;
	localparam int WP_CYC        = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int VID_SET_CYC   = (T_VID_SET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_PROT_US     = 150;   // Protect pulse wait
	localparam int T_UNPROT_US   = 15000; // Unprotect pulse wait

	// --------------------
	// Widths and bus layout
	// --------------------
	localparam int ADDR_W     = 19;
	localparam int DQ_W       = 16;
	localparam int SECTORS    = 22;
	localparam int SECT_IDX_W = 5;
	localparam int BANK_LSB   = 12;  // Sector and bank address A18..A12
	localparam int CNT_W      = 32;

	// --------------------
	// Command data and addresses
	// --------------------
	localparam logic [18:0] UNLOCK1_ADDR = 19'h00555;
	localparam logic [18:0] UNLOCK2_ADDR = 19'h002aa;
	localparam logic [11:0] CMD_LOW_ADDR = 12'h555;
	localparam logic [7:0]  UNLOCK1_DATA = 8'haa;
	localparam logic [7:0]  UNLOCK2_DATA = 8'h55;
	localparam logic [7:0]  IDENT_DATA   = 8'h90;
	localparam logic [7:0]  EXIT_DATA    = 8'hf0;
	localparam logic [7:0]  PROG_DATA    = 8'ha0;
	localparam logic [7:0]  PROT_SETUP   = 8'h60;
	localparam logic [7:0]  PROT_VERIFY  = 8'h40;

	// --------------------
	// Host operations and step kinds
	// --------------------
	typedef enum logic [3:0] {
		OP_HV_ID     = 4'h0,
		OP_HV_VERIFY = 4'h1,
		OP_SYS_ID    = 4'h2,
		OP_SYS_EXIT  = 4'h3,
		OP_PROGRAM   = 4'h4,
		OP_PROTECT   = 4'h5,
		OP_UNPROTECT = 4'h6,
		OP_TEMP      = 4'h7,
		OP_ALT_PROT  = 4'h8
	} fasp_op_t;

	typedef enum logic [1:0] {
		K_RD  = 2'h0,
		K_WR  = 2'h1,
		K_WT  = 2'h2,
		K_END = 2'h3
	} fasp_kind_t;

endpackage

// [rtl/fasp_cyc.sv]
// One asynchronous flash bus cycle, read or write, with pin timing.
// Assumes dq_in comes straight from the pins and is sampled through two flops.
`timescale 1ns/1ps
`default_nettype none
module fasp_cyc (
	input  wire logic                          clk_in,
	input  wire logic                          rst_n_in,
	input  wire logic                          start_in,
	input  wire logic                          write_in,
	input  wire logic [fasp_pkg::ADDR_W-1:0]   addr_in,
	input  wire logic [7:0]                    data_in,
	input  wire logic [fasp_pkg::DQ_W-1:0]     dq_in,
	output logic                               ce_n_out,
	output logic                               oe_n_out,
	output logic                               we_n_out,
	output logic [fasp_pkg::ADDR_W-1:0]        addr_out,
	output logic [fasp_pkg::DQ_W-1:0]          dq_out,
	output logic                               dq_oe_out,
	output logic [7:0]                         rdata_out,
	output logic                               done_out
);
	import fasp_pkg::*;

	typedef enum logic [1:0] {
		C_IDLE   = 2'h0,
		C_SETUP  = 2'h1,
		C_STROBE = 2'h2,
		C_HOLD   = 2'h3
	} fasp_cst_t;

	fasp_cst_t         st_q;
	logic              wr_q;
	logic [7:0]        cnt_q;
	logic [DQ_W-1:0]   dq_s1_q;
	logic [DQ_W-1:0]   dq_s2_q;

	// ------------------------------------------------------------
	// Pin input synchroniser
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			dq_s1_q <= '0;
			dq_s2_q <= '0;
		end else begin
			dq_s1_q <= dq_in;
			dq_s2_q <= dq_s1_q;
		end
	end

	// ------------------------------------------------------------
	// Cycle sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_q      <= C_IDLE;
			wr_q      <= 1'b0;
			cnt_q     <= 8'h00;
			ce_n_out  <= 1'b1;
			oe_n_out  <= 1'b1;
			we_n_out  <= 1'b1;
			addr_out  <= '0;
			dq_out    <= '0;
			dq_oe_out <= 1'b0;
			rdata_out <= 8'h00;
			done_out  <= 1'b0;
		end else begin
			done_out <= 1'b0;
			case (st_q)
				C_IDLE: begin
					if (start_in) begin
						wr_q      <= write_in;
						addr_out  <= addr_in;
						dq_out    <= {8'h00, data_in};
						dq_oe_out <= write_in;
						st_q      <= C_SETUP;
					end
				end
				C_SETUP: begin
					// Address settled; assert the strobes, OE held high on writes
					ce_n_out <= 1'b0;
					oe_n_out <= wr_q;
					we_n_out <= !wr_q;
					cnt_q    <= wr_q ? 8'(WP_CYC) : 8'(ACC_CYC);
					st_q     <= C_STROBE;
				end
				C_STROBE: begin
					if (cnt_q == 8'h01) begin
						if (!wr_q)
							rdata_out <= dq_s2_q[7:0];
						oe_n_out <= 1'b1;
						we_n_out <= 1'b1;
						st_q     <= C_HOLD;
					end else begin
						cnt_q <= cnt_q - 8'h01;
					end
				end
				C_HOLD: begin
					// Data held one cycle past the strobe release
					ce_n_out  <= 1'b1;
					dq_oe_out <= 1'b0;
					done_out  <= 1'b1;
					st_q      <= C_IDLE;
				end
				default: st_q <= C_IDLE;
			endcase
		end
	end

endmodule
`default_nettype wire

// [rtl/fasp_host.sv]
// Host controller for identification and sector protection of a dual-bank
// asynchronous flash: drives its pins and the elevated-voltage switches.
// Assumes external analog switches apply the elevated level when enabled.
//
// Summary of operation
// - Elevated level on A9 for programmer identification.
// - CE/OE low, WE high, A6 low, A1 low, A0 select.
// - Verify: sector address, A1 high, A0 low.
// - Protect all sectors before unprotecting.
// - Primary protect: elevated reset pin, normal cycles.
// - Alternate protect: elevated A9 and OE.
// - Identification mode held until reset command.
`timescale 1ns/1ps
`default_nettype none
module fasp_host #(
	parameter int PROT_CYC   = fasp_pkg::T_PROT_US * 1000 / fasp_pkg::CLK_PERIOD_NS,
	parameter int UNPROT_CYC = fasp_pkg::T_UNPROT_US * 1000 / fasp_pkg::CLK_PERIOD_NS
) (
	input  wire logic                             clk_in,
	input  wire logic                             rst_n_in,
	input  wire logic                             cmd_valid_in,
	input  wire fasp_pkg::fasp_op_t               cmd_op_in,
	input  wire logic [fasp_pkg::ADDR_W-1:0]      cmd_addr_in,
	input  wire logic [7:0]                       cmd_data_in,
	input  wire logic [fasp_pkg::SECT_IDX_W-1:0]  cmd_sector_in,
	output logic                                  cmd_ready_out,
	output logic                                  done_out,
	output logic                                  refused_out,
	output logic [7:0]                            rdata_out,
	output logic [fasp_pkg::SECTORS-1:0]          prot_map_out,
	output logic                                  temp_unprot_out,
	input  wire logic [fasp_pkg::DQ_W-1:0]        flash_dq_in,
	output logic [fasp_pkg::DQ_W-1:0]             flash_dq_out,
	output logic                                  flash_dq_oe_out,
	output logic [fasp_pkg::ADDR_W-1:0]           flash_addr_out,
	output logic                                  flash_ce_n_out,
	output logic                                  flash_oe_n_out,
	output logic                                  flash_we_n_out,
	output logic                                  flash_reset_n_out,
	output logic                                  elevated_id_voltage_a9_out,
	output logic                                  elevated_id_voltage_oe_out,
	output logic                                  elevated_id_voltage_rst_out
);
	import fasp_pkg::*;

	typedef enum logic [2:0] {
		S_IDLE  = 3'h0,
		S_HVSET = 3'h1,
		S_STEP  = 3'h2,
		S_CYC   = 3'h3,
		S_WAIT  = 3'h4
	} fasp_st_t;

	// --------------------
	// State
	// --------------------
	logic                  rst_s1_q;
	logic                  rst_q;
	fasp_st_t              st_q;
	fasp_op_t              op_q;
	logic [ADDR_W-1:0]     addr_q;
	logic [7:0]            data_q;
	logic [SECT_IDX_W-1:0] sect_q;
	logic [2:0]            step_q;
	logic [CNT_W-1:0]      cnt_q;
	logic                  cyc_start_q;
	logic                  cyc_done;
	logic [7:0]            cyc_rdata;
	fasp_kind_t            kind;
	logic [ADDR_W-1:0]     step_addr;
	logic [7:0]            step_data;
	logic [CNT_W-1:0]      step_wait;

	// --------------------
	// Reset release synchroniser
	// --------------------
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_s1_q <= 1'b0;
			rst_q    <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_q    <= rst_s1_q;
		end
	end

	// --------------------
	// Address forms
	// --------------------
	wire [6:0]        bank_addr = addr_q[ADDR_W-1:BANK_LSB];
	// Programmer identification: A6 low, A1 low, A0 picks maker or part
	wire [ADDR_W-1:0] hv_id_addr = {bank_addr, 5'h00, 1'b0, 4'h0, 1'b0, addr_q[0]};
	// Sector address on top lines, A1 high, A0 low; A6 picks protect/unprotect
	wire [ADDR_W-1:0] sa_prot_addr = {bank_addr, 5'h00, 1'b0, 4'h0, 2'b10};
	wire [ADDR_W-1:0] sa_unpr_addr = {bank_addr, 5'h00, 1'b1, 4'h0, 2'b10};
	wire [ADDR_W-1:0] ba_cmd_addr  = {bank_addr, CMD_LOW_ADDR};
	// In-system identification read: offset 0 maker, 1 part, 2 protection
	wire [ADDR_W-1:0] sys_id_addr  = {bank_addr, 10'h000, addr_q[1:0]};

	// --------------------
	// Step table per operation
	// --------------------
	always_comb begin
		kind      = K_END;
		step_addr = '0;
		step_data = 8'h00;
		step_wait = '0;
		case (op_q)
			OP_HV_ID: begin
				if (step_q == 3'd0) begin kind = K_RD; step_addr = hv_id_addr; end
			end
			OP_HV_VERIFY: begin
				if (step_q == 3'd0) begin kind = K_RD; step_addr = sa_prot_addr; end
			end
			OP_SYS_ID, OP_PROGRAM: begin
				// Two unlock writes precede the command write
				case (step_q)
					3'd0: begin kind = K_WR; step_addr = UNLOCK1_ADDR; step_data = UNLOCK1_DATA; end
					3'd1: begin kind = K_WR; step_addr = UNLOCK2_ADDR; step_data = UNLOCK2_DATA; end
					3'd2: begin
						kind      = K_WR;
						step_addr = ba_cmd_addr;
						step_data = (op_q == OP_SYS_ID) ? IDENT_DATA : PROG_DATA;
					end
					3'd3: begin
						kind      = (op_q == OP_SYS_ID) ? K_RD : K_WR;
						step_addr = (op_q == OP_SYS_ID) ? sys_id_addr : addr_q;
						step_data = data_q;
					end
					default: kind = K_END;
				endcase
			end
			OP_SYS_EXIT: begin
				if (step_q == 3'd0) begin kind = K_WR; step_data = EXIT_DATA; end
			end
			OP_PROTECT, OP_UNPROTECT: begin
				// Setup write, pulse wait, verify write, verify read
				step_addr = (op_q == OP_PROTECT) ? sa_prot_addr : sa_unpr_addr;
				step_wait = (op_q == OP_PROTECT) ? CNT_W'(PROT_CYC) : CNT_W'(UNPROT_CYC);
				case (step_q)
					3'd0: begin kind = K_WR; step_data = PROT_SETUP; end
					3'd1: kind = K_WT;
					3'd2: begin kind = K_WR; step_data = PROT_VERIFY; end
					3'd3: kind = K_RD;
					default: kind = K_END;
				endcase
			end
			OP_ALT_PROT: begin
				step_addr = sa_prot_addr;
				step_wait = CNT_W'(PROT_CYC);
				case (step_q)
					3'd0: kind = K_WR;
					3'd1: kind = K_WT;
					3'd2: kind = K_RD;
					default: kind = K_END;
				endcase
			end
			default: kind = K_END;
		endcase
	end

	// --------------------
	// Acceptance checks
	// --------------------
	wire all_prot    = &prot_map_out;
	wire refuse_unpr = (cmd_op_in == OP_UNPROTECT) && !all_prot;
	// Program into a known protected sector is pointless unless temporarily lifted
	wire refuse_prog = (cmd_op_in == OP_PROGRAM) && prot_map_out[cmd_sector_in] && !temp_unprot_out;
	wire accept      = cmd_valid_in && cmd_ready_out;
	wire need_a9     = (cmd_op_in == OP_HV_ID) || (cmd_op_in == OP_HV_VERIFY) || (cmd_op_in == OP_ALT_PROT);
	wire need_rst    = (cmd_op_in == OP_PROTECT) || (cmd_op_in == OP_UNPROTECT);

	// --------------------
	// Operation sequencer
	// --------------------
	always_ff @(posedge clk_in or negedge rst_q) begin
		if (!rst_q) begin
			st_q                        <= S_IDLE;
			op_q                        <= OP_HV_ID;
			addr_q                      <= '0;
			data_q                      <= 8'h00;
			sect_q                      <= '0;
			step_q                      <= 3'd0;
			cnt_q                       <= '0;
			cyc_start_q                 <= 1'b0;
			cmd_ready_out               <= 1'b0;
			done_out                    <= 1'b0;
			refused_out                 <= 1'b0;
			rdata_out                   <= 8'h00;
			prot_map_out                <= '0;
			temp_unprot_out             <= 1'b0;
			flash_reset_n_out           <= 1'b1;
			elevated_id_voltage_a9_out  <= 1'b0;
			elevated_id_voltage_oe_out  <= 1'b0;
			elevated_id_voltage_rst_out <= 1'b0;
		end else begin
			done_out    <= 1'b0;
			refused_out <= 1'b0;
			cyc_start_q <= 1'b0;
			case (st_q)
				S_IDLE: begin
					cmd_ready_out <= 1'b1;
					if (accept) begin
						cmd_ready_out <= 1'b0;
						op_q          <= cmd_op_in;
						addr_q        <= cmd_addr_in;
						data_q        <= cmd_data_in;
						sect_q        <= cmd_sector_in;
						step_q        <= 3'd0;
						if (refuse_unpr || refuse_prog) begin
							refused_out <= 1'b1;
						end else if (cmd_op_in == OP_TEMP) begin
							// Level on the reset pin lifts and restores protection
							temp_unprot_out             <= cmd_data_in[0];
							elevated_id_voltage_rst_out <= cmd_data_in[0];
							done_out                    <= 1'b1;
						end else begin
							elevated_id_voltage_a9_out  <= need_a9;
							elevated_id_voltage_oe_out  <= (cmd_op_in == OP_ALT_PROT);
							elevated_id_voltage_rst_out <= need_rst || temp_unprot_out;
							cnt_q                       <= CNT_W'(VID_SET_CYC);
							st_q                        <= S_HVSET;
						end
					end
				end
				S_HVSET: begin
					if (cnt_q <= CNT_W'(1))
						st_q <= S_STEP;
					else
						cnt_q <= cnt_q - CNT_W'(1);
				end
				S_STEP: begin
					if (kind == K_RD || kind == K_WR) begin
						cyc_start_q <= 1'b1;
						st_q        <= S_CYC;
					end else if (kind == K_WT) begin
						cnt_q <= step_wait;
						st_q  <= S_WAIT;
					end else begin
						// Finish: drop elevated levels, keep temporary unprotect level
						elevated_id_voltage_a9_out  <= 1'b0;
						elevated_id_voltage_oe_out  <= 1'b0;
						elevated_id_voltage_rst_out <= temp_unprot_out;
						rdata_out                   <= cyc_rdata;
						if (op_q == OP_HV_VERIFY || op_q == OP_PROTECT || op_q == OP_ALT_PROT)
							prot_map_out[sect_q] <= cyc_rdata[0];
						if (op_q == OP_UNPROTECT && !cyc_rdata[0])
							prot_map_out <= '0;
						done_out <= 1'b1;
						st_q     <= S_IDLE;
					end
				end
				S_CYC: begin
					if (cyc_done) begin
						step_q <= step_q + 3'd1;
						st_q   <= S_STEP;
					end
				end
				S_WAIT: begin
					if (cnt_q <= CNT_W'(1)) begin
						// OE leaves the elevated level before the verify read
						elevated_id_voltage_oe_out <= 1'b0;
						step_q                     <= step_q + 3'd1;
						st_q                       <= S_STEP;
					end else begin
						cnt_q <= cnt_q - CNT_W'(1);
					end
				end
				default: st_q <= S_IDLE;
			endcase
		end
	end

	// --------------------
	// Flash bus cycle engine
	// --------------------
	fasp_cyc u_cyc (
		.clk_in    (clk_in),
		.rst_n_in  (rst_q),
		.start_in  (cyc_start_q),
		.write_in  (kind == K_WR),
		.addr_in   (step_addr),
		.data_in   (step_data),
		.dq_in     (flash_dq_in),
		.ce_n_out  (flash_ce_n_out),
		.oe_n_out  (flash_oe_n_out),
		.we_n_out  (flash_we_n_out),
		.addr_out  (flash_addr_out),
		.dq_out    (flash_dq_out),
		.dq_oe_out (flash_dq_oe_out),
		.rdata_out (cyc_rdata),
		.done_out  (cyc_done)
	);

endmodule
`default_nettype wire

// [sim/fasp_host_monitor.sv]
// Checker for the flash identification and protection host controller.
// Assumes binding to fasp_host; every signal is in the clk_in domain.
`timescale 1ns/1ps
`default_nettype none
module fasp_host_monitor (
	input wire logic                            clk_in,
	input wire logic                            rst_n_in,
	input wire logic                            cmd_valid_in,
	input wire fasp_pkg::fasp_op_t              cmd_op_in,
	input wire logic [fasp_pkg::SECT_IDX_W-1:0] cmd_sector_in,
	input wire logic                            cmd_ready_out,
	input wire logic                            done_out,
	input wire logic                            refused_out,
	input wire logic [fasp_pkg::SECTORS-1:0]    prot_map_out,
	input wire logic                            temp_unprot_out,
	input wire logic [fasp_pkg::DQ_W-1:0]       flash_dq_out,
	input wire logic                            flash_dq_oe_out,
	input wire logic [fasp_pkg::ADDR_W-1:0]     flash_addr_out,
	input wire logic                            flash_ce_n_out,
	input wire logic                            flash_oe_n_out,
	input wire logic                            flash_we_n_out,
	input wire logic                            elevated_id_voltage_a9_out,
	input wire logic                            elevated_id_voltage_oe_out,
	input wire logic                            elevated_id_voltage_rst_out
);
	import fasp_pkg::*;
	logic     take;
	fasp_op_t op_q;
	assign take = cmd_valid_in && cmd_ready_out;
	// Operation in flight
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) op_q <= OP_HV_ID;
		else if (take) op_q <= cmd_op_in;
	end
	// --------------------
	// Properties
	// --------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	sequence take_s(fasp_op_t o);
		take && cmd_op_in == o;
	endsequence
	sequence settle_s;
		elevated_id_voltage_a9_out [*8];
	endsequence
	unprot_refuse_a: assert property (take_s(OP_UNPROTECT) ##0 !(&prot_map_out) |-> ##[1:2] refused_out)
		else $error("unprotect not refused");
	prog_refuse_a: assert property (take_s(OP_PROGRAM) ##0 (prot_map_out[cmd_sector_in] && !temp_unprot_out)
		|-> ##[1:2] refused_out) else $error("protected program not refused");
	temp_prog_a: assert property (take_s(OP_PROGRAM) ##0 temp_unprot_out |=> !refused_out [*2])
		else $error("program refused in temporary unprotect");
	hv_pins_a: assert property (elevated_id_voltage_a9_out && !elevated_id_voltage_oe_out && !flash_oe_n_out
		|-> !flash_ce_n_out && flash_we_n_out && !flash_addr_out[6]) else $error("bad identification read pins");
	dq_upper_a: assert property (flash_dq_oe_out |-> flash_dq_out[15:8] == 8'h00)
		else $error("upper data byte driven");
	hv_settle_a: assert property (take_s(OP_HV_ID) |=> settle_s)
		else $error("elevated A9 level not applied");
	hv_done_a: assert property (take_s(OP_HV_ID) |-> ##[401:700] done_out)
		else $error("identification read not completed");
	sys_plain_a: assert property (op_q == OP_SYS_ID && !cmd_ready_out
		|-> !elevated_id_voltage_a9_out && !elevated_id_voltage_oe_out) else $error("elevated level in command mode");
	temp_level_a: assert property (cmd_ready_out |-> elevated_id_voltage_rst_out == temp_unprot_out)
		else $error("reset pin level disagrees with mode");
	write_pulse_a: assert property ($fell(flash_we_n_out)
		|-> (!flash_we_n_out && !flash_ce_n_out && flash_oe_n_out && flash_dq_oe_out) [*5])
		else $error("short or malformed write cycle");
endmodule
bind fasp_host fasp_host_monitor fasp_host_monitor_inst (
	.clk_in, .rst_n_in, .cmd_valid_in, .cmd_op_in, .cmd_sector_in, .cmd_ready_out, .done_out, .refused_out,
	.prot_map_out, .temp_unprot_out, .flash_dq_out, .flash_dq_oe_out, .flash_addr_out, .flash_ce_n_out,
	.flash_oe_n_out, .flash_we_n_out, .elevated_id_voltage_a9_out, .elevated_id_voltage_oe_out,
	.elevated_id_voltage_rst_out
);
`default_nettype wire

// [sim/fasp_flash_model.sv]
// Behavioural flash device: identifier codes, sector flags, programming.
// Assumes word mode; one protection flag per A18..A12 address block.
`timescale 1ns/1ps
`default_nettype none
module fasp_flash_model #(
	parameter logic [7:0] MAKER_CODE = 8'h5a, // Arbitrary value
	parameter logic [7:0] PART_CODE  = 8'h3c  // Arbitrary value
) (
	input  wire logic [fasp_pkg::ADDR_W-1:0] addr_in,
	input  wire logic [fasp_pkg::DQ_W-1:0]   dq_in,
	input  wire logic                        ce_n_in,
	input  wire logic                        oe_n_in,
	input  wire logic                        we_n_in,
	input  wire logic                        rst_hv_in,
	input  wire logic                        a9_hv_in,
	input  wire logic                        oe_hv_in,
	output logic [fasp_pkg::DQ_W-1:0]        dq_out
);
	import fasp_pkg::*;
	logic [127:0] prot_q = '0;
	logic [7:0]   mem [128];
	logic [7:0]   rd;
	logic [7:0]   last_q = 8'h00;
	logic [1:0]   step_q = 2'h0;
	logic         id_q = 1'b0;
	logic         ver_q = 1'b0;
	logic [6:0]   sect;
	logic [7:0]   wd;
	assign sect = addr_in[18:12];
	assign wd = dq_in[7:0];
	initial foreach (mem[i]) mem[i] = 8'hff;
	// --------------------
	// Read paths
	// --------------------
	always_comb begin
		rd = mem[sect];
		if (a9_hv_in && addr_in[6]) begin
			rd = 8'hff;
		end else if (a9_hv_in || id_q || ver_q) begin
			case (addr_in[1:0])
				2'h0: rd = MAKER_CODE;
				2'h1: rd = PART_CODE;
				2'h2: rd = {7'h00, prot_q[sect]};
				default: rd = 8'h00;
			endcase
		end
	end
	// Driven only while read-selected, else a changing pattern
	assign dq_out = (!ce_n_in && !oe_n_in && we_n_in) ? {~rd, rd} : {last_q, ~last_q};
	always @(posedge oe_n_in) last_q <= ~rd;
	// Command decoding on the rising write strobe
	always @(posedge we_n_in) begin
		if (!ce_n_in) begin
			ver_q <= 1'b0;
			if (step_q == 2'h3) begin
				if (!prot_q[sect] || rst_hv_in) mem[sect] <= mem[sect] & wd;
				step_q <= 2'h0;
			end else if (rst_hv_in && wd == PROT_SETUP) begin
				if (addr_in[6]) prot_q <= '0;
				else prot_q[sect] <= 1'b1;
			end else if (rst_hv_in && wd == PROT_VERIFY) begin
				ver_q <= 1'b1;
			end else if (a9_hv_in && oe_hv_in) begin
				prot_q[sect] <= 1'b1;
			end else if (wd == EXIT_DATA) begin
				id_q <= 1'b0;
				step_q <= 2'h0;
			end else if (step_q == 2'h0 && addr_in[11:0] == CMD_LOW_ADDR && wd == UNLOCK1_DATA) begin
				step_q <= 2'h1;
			end else if (step_q == 2'h1 && addr_in[11:0] == UNLOCK2_ADDR[11:0] && wd == UNLOCK2_DATA) begin
				step_q <= 2'h2;
			end else if (step_q == 2'h2 && wd == IDENT_DATA) begin
				id_q <= 1'b1;
				step_q <= 2'h0;
			end else begin
				step_q <= (step_q == 2'h2 && wd == PROG_DATA) ? 2'h3 : 2'h0;
			end
		end
	end
endmodule
`default_nettype wire

// [sim/fasp_host_bench.sv]
// Self-checking bench for the flash identification and protection host.
// Assumes the flash model beside it and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module fasp_host_bench;
	import fasp_pkg::*;
	localparam logic [7:0] MAKER = 8'h5a; // Arbitrary value
	localparam logic [7:0] PART  = 8'h3c; // Arbitrary value
	logic                  clk_in = 1'b0;
	logic                  rst_n_in = 1'b0;
	logic                  cmd_valid_in = 1'b0;
	fasp_op_t              cmd_op_in = OP_HV_ID;
	logic [ADDR_W-1:0]     cmd_addr_in = '0;
	logic [7:0]            cmd_data_in = '0;
	logic [SECT_IDX_W-1:0] cmd_sector_in = '0;
	logic cmd_ready_out, done_out, refused_out, temp_unprot_out, flash_dq_oe_out, flash_ce_n_out, flash_oe_n_out;
	logic flash_we_n_out, flash_reset_n_out, elevated_id_voltage_a9_out, elevated_id_voltage_oe_out;
	logic elevated_id_voltage_rst_out, op_ok;
	logic [7:0]            rdata_out;
	logic [SECTORS-1:0]    prot_map_out;
	logic [DQ_W-1:0]       flash_dq_in, flash_dq_out, model_dq;
	logic [ADDR_W-1:0]     flash_addr_out;
	int                    fail_count = 0;
	int                    n_checks = 0;
	int                    cyc = 0;
	always #5 clk_in = ~clk_in;
	// Resolved data bus
	assign flash_dq_in = flash_dq_oe_out ? flash_dq_out : model_dq;
	fasp_host #(.PROT_CYC(20), .UNPROT_CYC(20)) fasp_host_inst (
		.clk_in, .rst_n_in, .cmd_valid_in, .cmd_op_in, .cmd_addr_in, .cmd_data_in, .cmd_sector_in, .cmd_ready_out,
		.done_out, .refused_out, .rdata_out, .prot_map_out, .temp_unprot_out, .flash_dq_in, .flash_dq_out,
		.flash_dq_oe_out, .flash_addr_out, .flash_ce_n_out, .flash_oe_n_out, .flash_we_n_out, .flash_reset_n_out,
		.elevated_id_voltage_a9_out, .elevated_id_voltage_oe_out, .elevated_id_voltage_rst_out);
	fasp_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) fasp_flash_model_inst (
		.addr_in(flash_addr_out), .dq_in(flash_dq_in), .ce_n_in(flash_ce_n_out), .oe_n_in(flash_oe_n_out),
		.we_n_in(flash_we_n_out), .rst_hv_in(elevated_id_voltage_rst_out), .a9_hv_in(elevated_id_voltage_a9_out),
		.oe_hv_in(elevated_id_voltage_oe_out), .dq_out(model_dq));
	// --------------------
	// Shared tasks
	// --------------------
	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
		cmp_map(22'(g), 22'(e));
	endtask
	task automatic cmp_map(input logic [21:0] g, input logic [21:0] e);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic cmp_bit(input logic g, input logic e);
		cmp_map(22'(g), 22'(e));
	endtask
	// One request, held until taken; result in op_ok
	task automatic do_op(input fasp_op_t op, input logic [18:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(negedge clk_in);
		while (cmd_ready_out !== 1'b1 && n < 5000) begin
			@(negedge clk_in);
			n++;
		end
		cmd_valid_in = 1'b1;
		cmd_op_in = op;
		cmd_addr_in = a;
		cmd_data_in = d;
		cmd_sector_in = a[16:12];
		@(negedge clk_in);
		cmd_valid_in = 1'b0;
		while (done_out !== 1'b1 && refused_out !== 1'b1 && n < 5000) begin
			@(negedge clk_in);
			n++;
		end
		if (n >= 5000) fail_count++; // Request hung
		op_ok = done_out;
	endtask
	// --------------------
	// Scenarios
	// --------------------
	task automatic t_ident();
		do_op(OP_HV_ID, 19'h7f000, 8'h00);
		cmp_byte(rdata_out, MAKER);
		do_op(OP_HV_ID, 19'h7f001, 8'h00);
		cmp_byte(rdata_out, PART);
		do_op(OP_SYS_ID, 19'h15000, 8'h00);
		cmp_byte(rdata_out, MAKER);
		do_op(OP_SYS_ID, 19'h15001, 8'h00);
		cmp_byte(rdata_out, PART);
		cmp_bit(fasp_flash_model_inst.id_q, 1'b1);
		do_op(OP_SYS_EXIT, 19'h15000, 8'h00);
		cmp_bit(fasp_flash_model_inst.id_q, 1'b0);
	endtask
	task automatic t_protect();
		do_op(OP_PROTECT, 19'h03000, 8'h00);
		cmp_map(prot_map_out, 22'h000008);
		do_op(OP_HV_VERIFY, 19'h03000, 8'h00);
		cmp_byte(rdata_out, 8'h01);
		do_op(OP_HV_VERIFY, 19'h04000, 8'h00);
		cmp_byte(rdata_out, 8'h00);
		do_op(OP_ALT_PROT, 19'h06000, 8'h00);
		cmp_map(prot_map_out, 22'h000048);
		do_op(OP_PROGRAM, 19'h03010, 8'h11);
		cmp_bit(op_ok, 1'b0);
		cmp_byte(fasp_flash_model_inst.mem[3], 8'hff);
		do_op(OP_PROGRAM, 19'h05010, 8'h3c);
		cmp_byte(fasp_flash_model_inst.mem[5], 8'h3c);
	endtask
	task automatic t_temp();
		do_op(OP_TEMP, 19'h00000, 8'h01);
		cmp_bit(temp_unprot_out, 1'b1);
		cmp_bit(flash_reset_n_out, 1'b1);
		do_op(OP_PROGRAM, 19'h03020, 8'ha5);
		cmp_byte(fasp_flash_model_inst.mem[3], 8'ha5);
		do_op(OP_TEMP, 19'h00000, 8'h00);
		cmp_bit(temp_unprot_out, 1'b0);
		do_op(OP_HV_VERIFY, 19'h03000, 8'h00);
		cmp_byte(rdata_out, 8'h01);
		do_op(OP_PROGRAM, 19'h03020, 8'h00);
		cmp_bit(op_ok, 1'b0);
	endtask
	task automatic t_unprot();
		do_op(OP_UNPROTECT, 19'h00000, 8'h00);
		cmp_bit(op_ok, 1'b0);
		for (int i = 0; i < SECTORS; i++) begin
			if (!prot_map_out[i]) do_op(OP_PROTECT, {7'(i), 12'h000}, 8'h00);
		end
		cmp_map(prot_map_out, 22'h3fffff);
		do_op(OP_UNPROTECT, 19'h00000, 8'h00);
		cmp_map(prot_map_out, 22'h000000);
		do_op(OP_HV_VERIFY, 19'h03000, 8'h00);
		cmp_byte(rdata_out, 8'h00);
		do_op(OP_PROGRAM, 19'h03030, 8'h21);
		cmp_byte(fasp_flash_model_inst.mem[3], 8'h21);
	endtask
	// Cycle ceiling against hangs
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 60000) begin
			fail_count++;
			final_report();
		end
	end
	// Main sequence
	initial begin
		repeat (5) @(negedge clk_in);
		rst_n_in = 1'b1;
		cmp_map(prot_map_out, 22'h000000);
		t_ident();
		t_protect();
		t_temp();
		t_unprot();
		final_report();
	end
endmodule
`default_nettype wire
